// >>> verilog/lsf_pkg.sv
// Purpose: Shared constants for the limit-status flag block
// Assumes: Register indices sit at byte address four times the index
// Notes:   Register offsets, config and pin fields, register reset values and counts live here
package lsf_pkg;
    // Register indices (byte address is four times the index)
    localparam logic [7:0] REG_CONFIG_ONE    = 8'h40;
    localparam logic [7:0] REG_STATUS_FIRST  = 8'h41;
    localparam logic [7:0] REG_STATUS_SECOND = 8'h42;
    localparam logic [7:0] REG_LIMIT_FIRST   = 8'h44;
    localparam logic [7:0] REG_LIMIT_LAST    = 8'h53;
    localparam logic [7:0] REG_MASK_SECOND   = 8'h75;
    localparam logic [7:0] REG_PIN_SELECT    = 8'h7E;

    // Reset values
    localparam logic [7:0] CONFIG_ONE_RESET  = 8'h04;
    localparam logic [6:0] STATUS_ONE_RESET  = 7'h00;
    localparam logic [7:0] STATUS_TWO_RESET  = 8'h00;
    localparam logic [7:0] MASK_TWO_RESET    = 8'h00;
    localparam logic [7:0] PIN_SELECT_RESET  = 8'h00;
    localparam logic [7:0] LIMIT_LOW_RESET   = 8'h00;
    localparam logic [7:0] LIMIT_HIGH_RESET  = 8'hFF;

    // Configuration register one fields
    localparam int         CFG_START_BIT     = 0;
    localparam int         CFG_LOCK_BIT      = 1;
    localparam int         CFG_FULL_SPD_BIT  = 3;
    localparam logic [7:0] CFG_FREE_MASK     = 8'h29;
    localparam logic [7:0] CFG_LOCKABLE_MASK = 8'h50;
    localparam logic [7:0] CFG_READY_MASK    = 8'h04;

    // Pin select field and status layout
    localparam int         PIN_THERMAL_BIT   = 0;
    localparam int         SUMMARY_BIT       = 7;

    // Measurement channels and limit storage
    localparam int         NUM_CHANNELS      = 8;
    localparam int         NUM_LIMITS        = 16;
    localparam int         CH_RAIL_25V       = 0;
    localparam int         CH_RAIL_12V       = 4;

    // Bus constants
    localparam logic [1:0] HTRANS_NONSEQ     = 2'b10;
    localparam logic       HRESP_OKAY        = 1'b0;
endpackage

// >>> verilog/lsf_window_cmp.sv
// Purpose: Window comparison of one reading against its two limits
// Assumes: Readings and limits are unsigned codes of one byte
// Notes:   Falls back to the power-up window while monitoring is off
`timescale 1ns/1ns
module lsf_window_cmp (
    // Reading and limits
    input  wire logic [7:0] i_reading,
    input  wire logic [7:0] i_low,
    input  wire logic [7:0] i_high,
    // Mode
    input  wire logic       i_use_limits,
    // Result
    output logic            o_outside
);
    logic [7:0] low_eff;
    logic [7:0] high_eff;

    // Programmed limits are kept, only bypassed while stopped
    always_comb begin
        low_eff   = i_use_limits ? i_low  : lsf_pkg::LIMIT_LOW_RESET;
        high_eff  = i_use_limits ? i_high : lsf_pkg::LIMIT_HIGH_RESET;
        o_outside = (i_reading < low_eff) || (i_reading > high_eff);
    end
endmodule

// >>> verilog/lsf_top.sv
// Purpose: Latched limit-status flags with an AHB-Lite register port
// Assumes: One whole-word transfer at a time; measurements synchronous
// Notes:   Reads take one wait state so read side effects stay exact
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ns

module lsf_top (
    // Clock, enable and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_clk_en,
    input  wire logic        i_reset,
    // AHB-Lite slave port
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Measurements, one conversion per strobe
    input  wire logic        i_conv_valid,
    input  wire logic [7:0]  i_rail_25v,
    input  wire logic [7:0]  i_core_rail,
    input  wire logic [7:0]  i_supply_rail,
    input  wire logic [7:0]  i_rail_5v,
    input  wire logic [7:0]  i_rail_12v,
    input  wire logic [7:0]  i_remote_one_temp,
    input  wire logic [7:0]  i_local_temp,
    input  wire logic [7:0]  i_remote_two_temp,
    // Other event conditions, levels
    input  wire logic        i_thermal_timer_over,
    input  wire logic [6:0]  i_second_conditions,
    // System outputs
    output logic             o_alert,
    output logic             o_fan_full_duty,
    output logic             o_monitor_start_bit
);
    typedef enum logic [1:0] {
        LSF_IDLE,
        LSF_WRITE,
        LSF_READ_WAIT,
        LSF_READ_DONE
    } lsf_bus_e;

    // Limit registers sit on consecutive indices, low then high
    function automatic logic is_limit(input logic [7:0] idx);
        is_limit = (idx >= lsf_pkg::REG_LIMIT_FIRST) &&
                   (idx <= lsf_pkg::REG_LIMIT_LAST);
    endfunction

    function automatic logic [3:0] limit_slot(input logic [7:0] idx);
        logic [7:0] diff;
        diff       = idx - lsf_pkg::REG_LIMIT_FIRST;
        limit_slot = diff[3:0];
    endfunction

    // Bus state
    lsf_bus_e    state;
    lsf_bus_e    next_state;
    logic [7:0]  addr;
    logic [7:0]  next_addr;
    logic [31:0] next_hrdata;

    // Register state
    logic [7:0]  cfg;
    logic [7:0]  next_cfg;
    logic [6:0]  status_one;
    logic [6:0]  next_status_one;
    logic [7:0]  status_two;
    logic [7:0]  next_status_two;
    logic [7:0]  mask_two;
    logic [7:0]  next_mask_two;
    logic [7:0]  pin_select;
    logic [7:0]  next_pin_select;
    logic [7:0]  limit      [lsf_pkg::NUM_LIMITS];
    logic [7:0]  next_limit [lsf_pkg::NUM_LIMITS];
    logic [7:0]  cond;
    logic [7:0]  next_cond;

    // Combinational helpers
    logic [7:0]  reading [lsf_pkg::NUM_CHANNELS];
    logic [7:0]  outside;
    logic        accept;
    logic        do_write;
    logic        do_read;
    logic        locked;
    logic        thermal_mode;
    logic        summary;
    logic [7:0]  read_value;
    logic [6:0]  present_one;
    logic [6:0]  set_one;
    logic [7:0]  present_two;
    logic [7:0]  set_two;
    logic        bit0_present;
    logic        bit0_set;

    // Channel order matches the limit register order
    assign reading[0] = i_rail_25v;
    assign reading[1] = i_core_rail;
    assign reading[2] = i_supply_rail;
    assign reading[3] = i_rail_5v;
    assign reading[4] = i_rail_12v;
    assign reading[5] = i_remote_one_temp;
    assign reading[6] = i_local_temp;
    assign reading[7] = i_remote_two_temp;

    // One window comparator per channel
    for (genvar ch = 0; ch < lsf_pkg::NUM_CHANNELS; ch++) begin : g_cmp
        lsf_window_cmp u_cmp (
            .i_reading    (reading[ch]),
            .i_low        (limit[2*ch]),
            .i_high       (limit[2*ch+1]),
            .i_use_limits (cfg[lsf_pkg::CFG_START_BIT]),
            .o_outside    (outside[ch])
        );
    end

    // Decode of the current bus phase
    always_comb begin
        // NONSEQ and SEQ both carry the top bit; IDLE and BUSY never start
        accept       = i_hsel && i_hready && i_htrans[1];
        do_write     = (state == LSF_WRITE);
        do_read      = (state == LSF_READ_WAIT);
        locked       = cfg[lsf_pkg::CFG_LOCK_BIT];
        thermal_mode = pin_select[lsf_pkg::PIN_THERMAL_BIT];
        summary      = |status_two;
    end

    // Bus sequencing; reads wait one cycle so data comes from a flop
    always_comb begin
        next_state = state;
        next_addr  = addr;
        case (state)
            LSF_READ_WAIT: next_state = LSF_READ_DONE;
            default: begin
                next_state = LSF_IDLE;
                if (accept) begin
                    // Upper address bits force an unmapped index
                    next_addr  = (i_haddr[31:10] == 22'h00_0000) ?
                                 i_haddr[9:2] : 8'hFF;
                    next_state = i_hwrite ? LSF_WRITE : LSF_READ_WAIT;
                end
            end
        endcase
    end

    // Read multiplexer; unmapped indices read as zero
    always_comb begin
        read_value = 8'h00;
        case (addr)
            lsf_pkg::REG_CONFIG_ONE:    read_value = cfg;
            lsf_pkg::REG_STATUS_FIRST:  read_value = {summary, status_one};
            lsf_pkg::REG_STATUS_SECOND: read_value = status_two;
            lsf_pkg::REG_MASK_SECOND:   read_value = mask_two;
            lsf_pkg::REG_PIN_SELECT:    read_value = pin_select;
            default: begin
                if (is_limit(addr)) begin
                    read_value = limit[limit_slot(addr)];
                end
            end
        endcase
        next_hrdata = do_read ? {24'h00_0000, read_value} : o_hrdata;
    end

    // Conditions follow the latest conversion, flagged the same cycle
    always_comb begin
        next_cond    = i_conv_valid ? outside : cond;
        // In pin mode the timer replaces the 2.5 V reading on bit 0
        bit0_present = thermal_mode ? i_thermal_timer_over
                                    : next_cond[lsf_pkg::CH_RAIL_25V];
        bit0_set     = thermal_mode ? i_thermal_timer_over
                                    : i_conv_valid && outside[0];
        present_one  = {next_cond[7:5], next_cond[3:1], bit0_present};
        // Rails sit on bits 1 to 3, temperatures on bits 4 to 6
        set_one[0]   = bit0_set;
        set_one[1]   = i_conv_valid && outside[1];
        set_one[2]   = i_conv_valid && outside[2];
        set_one[3]   = i_conv_valid && outside[3];
        set_one[4]   = i_conv_valid && outside[5];
        set_one[5]   = i_conv_valid && outside[6];
        set_one[6]   = i_conv_valid && outside[7];
        present_two  = {i_second_conditions,
                        next_cond[lsf_pkg::CH_RAIL_12V]};
        set_two      = {i_second_conditions,
                        i_conv_valid && outside[lsf_pkg::CH_RAIL_12V]};
    end

    // Sticky flags: a set in the clearing cycle wins over the clear
    always_comb begin
        next_status_one = status_one | set_one;
        next_status_two = status_two | set_two;
        // Presence uses this cycle's result, so a fresh reading counts
        if (do_read && addr == lsf_pkg::REG_STATUS_FIRST) begin
            next_status_one = (status_one & present_one)
                              | set_one;
        end
        if (do_read && addr == lsf_pkg::REG_STATUS_SECOND) begin
            next_status_two = (status_two & present_two)
                              | set_two;
        end
    end

    // Register writes; status registers ignore writes
    always_comb begin
        next_cfg        = cfg;
        next_mask_two   = mask_two;
        next_pin_select = pin_select;
        next_limit      = limit;
        if (do_write) begin
            case (addr)
                lsf_pkg::REG_CONFIG_ONE: begin
                    // Start and full-speed bits ignore the lock
                    next_cfg = (cfg & ~lsf_pkg::CFG_FREE_MASK)
                               | (i_hwdata[7:0]
                                  & lsf_pkg::CFG_FREE_MASK);
                    if (!locked) begin
                        next_cfg = (next_cfg & ~lsf_pkg::CFG_LOCKABLE_MASK)
                                   | (i_hwdata[7:0]
                                      & lsf_pkg::CFG_LOCKABLE_MASK);
                        next_cfg[lsf_pkg::CFG_LOCK_BIT] =
                            i_hwdata[lsf_pkg::CFG_LOCK_BIT];
                    end
                end
                // Mask and pin select stay writable under the lock
                lsf_pkg::REG_MASK_SECOND:  next_mask_two   = i_hwdata[7:0];
                lsf_pkg::REG_PIN_SELECT:   next_pin_select = i_hwdata[7:0];
                default: begin
                    // Limits freeze once locked, only power-up frees them
                    if (is_limit(addr) && !locked) begin
                        next_limit[limit_slot(addr)] = i_hwdata[7:0];
                    end
                end
            endcase
        end
        next_cfg = next_cfg | lsf_pkg::CFG_READY_MASK;
    end

    // State registers; reset wins, otherwise the enable freezes everything while low
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state      <= LSF_IDLE;
            addr       <= 8'h00;
            o_hrdata   <= 32'h0000_0000;
            cfg        <= lsf_pkg::CONFIG_ONE_RESET;
            status_one <= lsf_pkg::STATUS_ONE_RESET;
            status_two <= lsf_pkg::STATUS_TWO_RESET;
            mask_two   <= lsf_pkg::MASK_TWO_RESET;
            pin_select <= lsf_pkg::PIN_SELECT_RESET;
            cond       <= 8'h00;
            for (int i = 0; i < lsf_pkg::NUM_LIMITS; i++) begin
                limit[i] <= i[0] ? lsf_pkg::LIMIT_HIGH_RESET
                                 : lsf_pkg::LIMIT_LOW_RESET;
            end
        end else if (i_clk_en) begin
            state      <= next_state;
            addr       <= next_addr;
            o_hrdata   <= next_hrdata;
            cfg        <= next_cfg;
            status_one <= next_status_one;
            status_two <= next_status_two;
            mask_two   <= next_mask_two;
            pin_select <= next_pin_select;
            cond       <= next_cond;
            limit      <= next_limit;
        end
    end

    // Bus handshake and system levels
    always_comb begin
        // Only reads stall, so read data always comes from a flop
        o_hreadyout         = (state != LSF_READ_WAIT);
        o_hresp             = lsf_pkg::HRESP_OKAY;
        o_monitor_start_bit = cfg[lsf_pkg::CFG_START_BIT];
        // Full duty protects the system while limits are not applied
        o_fan_full_duty     = !cfg[lsf_pkg::CFG_START_BIT]
                              || cfg[lsf_pkg::CFG_FULL_SPD_BIT];
        // Fully masked second register: alert is first-register flags or inverted summary
        o_alert             = (|status_one)
                              || (|(status_two & ~mask_two))
                              || ((&mask_two) && !summary);
    end
endmodule

// >>> dv/lsf_top_chk.sv
// Purpose: Bus and status relations of the limit-status block
// Assumes: Clock enable dropped only while the bus is idle
// Notes:   Sees the top module's ports only
`timescale 1ns/1ns
module lsf_top_chk (
    // Clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_clk_en,
    input wire logic        i_reset,
    // Bus
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    // Status side
    input wire logic [6:0]  i_second_conditions,
    input wire logic        o_alert,
    input wire logic        o_fan_full_duty,
    input wire logic        o_monitor_start_bit
);
    logic take;
    logic rd_s1;
    logic wr_cfg;
    logic next_wr_cfg;
    // Transfer accepted at this edge
    assign take  = i_hsel & i_hready & i_htrans[1] & i_clk_en;
    assign rd_s1 = take & !i_hwrite &
                   (i_haddr[9:2] == lsf_pkg::REG_STATUS_FIRST);
    // Config write waiting for its data phase
    always_comb next_wr_cfg = !i_reset & take & i_hwrite &
                              (i_haddr[9:2] == lsf_pkg::REG_CONFIG_ONE);
    always_ff @(posedge i_ref_clk) wr_cfg <= next_wr_cfg;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_hresp_okay: assert property (o_hresp == lsf_pkg::HRESP_OKAY)
        else $error("error response seen");
    a_reset_vals: assert property (disable iff (1'b0)
        i_reset & i_clk_en |=> o_hrdata == 32'h0000_0000 &&
        !o_monitor_start_bit && o_fan_full_duty)
        else $error("outputs not at reset values");
    a_read_wait: assert property (take & !i_hwrite
        |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read wait state wrong");
    a_write_fast: assert property (
        take & i_hwrite |=> o_hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property (
        o_hreadyout |=> $stable(o_hrdata))
        else $error("read data moved");
    a_rdata_byte: assert property (o_hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_fan_full: assert property (
        !o_monitor_start_bit |-> o_fan_full_duty)
        else $error("fan not at full duty");
    a_start_write: assert property (wr_cfg |=>
        o_monitor_start_bit == $past(i_hwdata[0]))
        else $error("start bit not written");
    a_summary_read: assert property (
        rd_s1 && i_second_conditions != 7'h00
        |=> ##1 o_hrdata[lsf_pkg::SUMMARY_BIT])
        else $error("summary bit clear");
    a_alert_flags: assert property (rd_s1 ##1 !o_alert
        |=> o_hrdata[6:0] == 7'h00)
        else $error("flag set without alert");
endmodule

// >>> dv/lsf_host.sv
// Purpose: Host side model driving the register bus
// Assumes: Single word transfers, one at a time
// Notes:   Released write data is inverted so stale values never match
`timescale 1ns/1ns
module lsf_host (
    // Clock and answer
    input  wire logic        i_clk,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hrdata,
    // Request
    output logic             o_hsel,
    output logic [31:0]      o_haddr,
    output logic [1:0]       o_htrans,
    output logic             o_hwrite,
    output logic [2:0]       o_hsize,
    output logic [31:0]      o_hwdata
);
    // Idle bus at time zero
    initial begin
        o_hsel   = 1'b0;
        o_haddr  = 32'h0000_0000;
        o_htrans = 2'b00;
        o_hwrite = 1'b0;
        o_hsize  = 3'b010;
        o_hwdata = 32'h0000_0000;
    end
    // Ready and read data are both taken at the edge that ends a phase
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk);
        o_hsel   <= 1'b1;
        o_htrans <= lsf_pkg::HTRANS_NONSEQ;
        o_haddr  <= {22'h00_0000, idx, 2'b00};
        o_hwrite <= wr;
        do begin
            @(posedge i_clk);
        end while (!i_hready);
        o_htrans <= 2'b00;
        o_hwdata <= wr ? d : ~o_hwdata;
        do begin
            @(posedge i_clk);
        end while (!i_hready);
        q = i_hrdata;
        o_hsel   <= 1'b0;
        o_hwdata <= ~d;
    endtask
endmodule

// >>> dv/lsf_top_bench.sv
// Purpose: Self-checking bench of the limit-status block
// Assumes: Clock enable dropped once, with the bus idle
// Notes:   Model state is plain integers updated per transfer
`timescale 1ns/1ns
module lsf_top_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        conv = 1'b0;
    logic        ce = 1'b1;
    logic        thermal_assert_pin = 1'b0;
    logic [6:0]  cond2 = 7'h00;
    logic [7:0]  rd [8] = '{default: 8'h00};
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hsel, hwrite, hready, hresp, alert, fan, start;
    logic [15:0] seed = 16'h0D87;
    int          n_errors, total_checks, cycles, v, nx[8], lim[16];
    int          m_s1, m_s2, m_c, m_cfg = 4, m_mask, m_pin;
    lsf_top u_lsf_top (.i_ref_clk(clk), .i_clk_en(ce), .i_reset(rst),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_conv_valid(conv), .i_rail_25v(rd[0]),
        .i_core_rail(rd[1]), .i_supply_rail(rd[2]), .i_rail_5v(rd[3]),
        .i_rail_12v(rd[7]), .i_remote_one_temp(rd[4]),
        .i_local_temp(rd[5]), .i_remote_two_temp(rd[6]),
        .i_thermal_timer_over(thermal_assert_pin), .i_second_conditions(cond2),
        .o_alert(alert), .o_fan_full_duty(fan), .o_monitor_start_bit(start));
    lsf_host host (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
    always #4 clk = ~clk;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    function automatic int pick(input bit out);
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        if (!out) return 8'h40 + seed % 8'h81;
        return seed[0] ? seed % 8'h40 : 8'hC1 + seed % 8'h3F;
    endfunction
    function automatic int lo_of(input int i);
        return i < 4 ? 2 * i : (i == 7 ? 8 : 2 * i + 2);
    endfunction
    // Read value, then clear flags whose cause has gone
    function automatic int m_read(input int idx);
        int r = 0;
        if (idx == 8'h41) begin
            r = m_s1 | (m_s2 != 0 ? 8'h80 : 8'h00);
            m_s1 &= m_pin ? (m_c & 8'h7E) | thermal_assert_pin : m_c;
        end else if (idx == 8'h42) begin
            r = m_s2;
            m_s2 &= (m_c >> 7) | (cond2 << 1);
        end else if (idx == 8'h40) r = m_cfg;
        else if (idx >= 8'h44 && idx <= 8'h53) r = lim[idx - 8'h44];
        return r;
    endfunction
    task automatic chk(input string what, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic outs();
        #1;
        chk("alert", m_s1 != 0 || (m_s2 & ~m_mask & 8'hFF) != 0 ||
            (m_mask == 8'hFF && m_s2 == 0), alert);
        chk("fan", !(m_cfg & 1) || (m_cfg & 8), fan);
        chk("start", m_cfg & 1, start);
    endtask
    task automatic rrd(input int idx);
        int e;
        logic [31:0] q;
        e = m_read(idx);
        host.xfer(1'b0, idx[7:0], 32'h0000_0000, q);
        chk($sformatf("reg %h", idx[7:0]), e, q);
        outs();
    endtask
    task automatic wr(input int idx, input int d);
        logic [31:0] q;
        host.xfer(1'b1, idx[7:0], d, q);
        if (idx == 8'h40)
            m_cfg = 4 | (d & 8'h29) | (m_cfg & 2 ? m_cfg & 8'h52 : d & 8'h52);
        else if (idx >= 8'h44 && idx <= 8'h53 && !(m_cfg & 2))
            lim[idx - 8'h44] = d;
        else if (idx == 8'h75) m_mask = d;
        else if (idx == 8'h7E) m_pin = d & 1;
        outs();
    endtask
    // One conversion of nx, flags set on that same edge
    task automatic go();
        @(posedge clk);
        foreach (rd[i]) rd[i] <= nx[i][7:0];
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        m_c = 0;
        for (int i = 0; i < 8; i++)
            if (m_cfg & 1 && (nx[i] < lim[lo_of(i)] ||
                              nx[i] > lim[lo_of(i) + 1]))
                m_c |= 1 << i;
        // In pin mode the 2.5 V reading no longer reaches bit 0
        m_s1 |= m_c & (m_pin ? 8'h7E : 8'h7F);
        m_s2 |= m_c >> 7;
        outs();
    endtask
    // Level inputs: second register causes and thermal timer
    task automatic lvl(input int c, input logic t);
        @(posedge clk);
        cond2 <= c[6:0];
        thermal_assert_pin <= t;
        @(posedge clk);
        m_s2 |= c << 1;
        m_s1 |= t & m_pin;
        outs();
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 16; i++) lim[i] = i % 2 ? 8'hFF : 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rrd(8'h41);
        rrd(8'h42);
        rrd(8'h40);
        rrd(8'h10);
        wr(8'h41, 8'hFF);
        rrd(8'h41);
        for (int i = 0; i < 8; i++) begin
            wr(8'h44 + lo_of(i), 8'h40);
            wr(8'h45 + lo_of(i), 8'hC0);
        end
        foreach (nx[i]) nx[i] = pick(1);
        go();
        rrd(8'h41);
        wr(8'h40, 8'h01);
        $display("test defaults done");
        for (int i = 0; i < 8; i++) begin
            foreach (nx[j]) nx[j] = pick(j == i);
            go();
            repeat (2) rrd(i < 7 ? 8'h41 : 8'h42);
            foreach (nx[j]) nx[j] = pick(0);
            go();
            repeat (2) rrd(i < 7 ? 8'h41 : 8'h42);
        end
        $display("test flags done");
        v = pick(1) % 8'h7F + 1;
        lvl(v, 1'b0);
        rrd(8'h41);
        wr(8'h75, 8'hFF);
        lvl(0, 1'b0);
        repeat (2) rrd(8'h42);
        wr(8'h75, 8'h00);
        wr(8'h7E, 8'h01);
        lvl(0, 1'b1);
        lvl(0, 1'b0);
        repeat (2) rrd(8'h41);
        wr(8'h7E, 8'h00);
        $display("test summary done");
        wr(8'h40, 8'h53);
        wr(8'h44, 8'h00);
        rrd(8'h44);
        wr(8'h40, 8'h28);
        rrd(8'h40);
        wr(8'h40, 8'h09);
        wr(8'h40, 8'h01);
        nx[0] = 8'h30;
        go();
        rrd(8'h41);
        // Enable low for one edge: this conversion must be ignored
        @(posedge clk);
        ce    <= 1'b0;
        rd[1] <= 8'hF0;
        conv  <= 1'b1;
        @(posedge clk);
        ce    <= 1'b1;
        conv  <= 1'b0;
        outs();
        rrd(8'h41);
        $display("test lock done");
        finish_test();
    end
endmodule
bind lsf_top lsf_top_chk u_chk (.i_ref_clk(i_ref_clk), .i_clk_en(i_clk_en),
    .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_second_conditions(i_second_conditions),
    .o_alert(o_alert), .o_fan_full_duty(o_fan_full_duty),
    .o_monitor_start_bit(o_monitor_start_bit));
